//--- verilog/acc_conv_ctrl.sv
// converter control: wishbone registers, sequencer and sar engine
`timescale 1ns/1ps
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int RES_W = 8, // converter resolution
  parameter int PINS = 16 // analog-capable port pins
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // classic wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [11:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  // power state of the cpu
  input wire logic I_HALT,
  // analog front end
  input wire logic I_COMPARATOR,
  output logic O_CONVERTER_POWER,
  output logic [ACC_CH_W-1:0] O_CHANNEL_SELECT,
  output logic O_SAMPLE,
  output logic [RES_W-1:0] O_DAC_CODE,
  // port pins seen as logic levels
  input wire logic [PINS-1:0] I_PIN_LEVEL,
  output logic [PINS-1:0] O_PIN_LEVEL
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (RES_W != 8) begin : g_bad_res
      $error("acc_conv_ctrl: result register is eight bits wide");
    end
    if (PINS < 1 || PINS > 16) begin : g_bad_pins
      $error("acc_conv_ctrl: between 1 and 16 pins supported");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic bus_req; // cycle and strobe both high
  logic hit_result; // address decodes to the result register
  logic hit_csr; // address decodes to control/status
  logic wr_csr; // control/status write takes effect now
  logic rd_result; // result read completes now
  logic wr_on; // converter_on bit of the written byte
  logic restart; // write with converter_on set
  logic run; // converter powered for this cycle's decision
  logic ctrl_on; // converter_on bit
  logic [ACC_CH_W-1:0] ctrl_ch; // channel_select field
  logic done_flag; // conversion_done_flag
  logic need_settle; // halt seen, settling not yet finished
  acc_state_type state; // sequencer state
  acc_state_type next_state; // sequencer state next cycle
  logic adc_phase; // converter clock enable toggle
  logic tick; // one converter clock period ends
  logic [3:0] period_cnt; // periods within the current phase
  logic [11:0] settle_cnt; // cycles spent settling
  logic sar_clear; // hold trial at mid scale
  logic sar_step; // one approximation step
  logic sar_done; // result just captured
  logic [RES_W-1:0] sar_trial; // trial code from the engine
  logic [RES_W-1:0] sar_result; // last result from the engine
  logic [7:0] csr_view; // control/status as read back
  logic [31:0] rd_mux; // read data before the output register

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // only the low byte lane carries register data
  always_comb begin
    bus_req = I_WB_CYC & I_WB_STB;
    hit_result = (I_WB_ADR[11:2] == ACC_IDX_RESULT);
    hit_csr = (I_WB_ADR[11:2] == ACC_IDX_CSR);
    // writes land at the edge where ack is sampled high
    wr_csr = bus_req & I_WB_WE & O_WB_ACK & hit_csr & I_WB_SEL[0];
    rd_result = bus_req & ~I_WB_WE & O_WB_ACK & hit_result;
    wr_on = I_WB_DAT[ACC_BIT_ON];
    restart = wr_csr & wr_on;
  end

  // read-back view of control/status, reserved bits forced low
  always_comb begin
    csr_view = 8'h00;
    csr_view[ACC_BIT_DONE] = done_flag;
    csr_view[ACC_BIT_ON] = ctrl_on;
    csr_view[ACC_CH_LSB +: ACC_CH_W] = ctrl_ch;
  end

  // read data multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = ACC_BUS_ZERO;
    if (hit_result) begin
      rd_mux[7:0] = sar_result;
    end else if (hit_csr) begin
      rd_mux[7:0] = csr_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone answer

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= bus_req & ~O_WB_ACK;
    end
  end

  // read data registered together with ack, held until the next answer
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_WB_DAT <= ACC_BUS_ZERO;
    end else if (bus_req && !O_WB_ACK) begin
      O_WB_DAT <= I_WB_WE ? ACC_BUS_ZERO : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // software-owned fields; the result register ignores writes
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ctrl_on <= 1'b0;
      ctrl_ch <= ACC_CH_RESET;
    end else if (wr_csr) begin
      ctrl_on <= wr_on;
      ctrl_ch <= I_WB_DAT[ACC_CH_LSB +: ACC_CH_W];
    end
  end

  // done flag: hardware sets it, a result read or a control/status write clears it, set wins
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      done_flag <= 1'b0;
    end else if (sar_done) begin
      done_flag <= 1'b1;
    end else if (wr_csr || rd_result) begin
      done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state

  // the converter runs on its own bit and halt only; wait mode is
  // not an input here, so it cannot disturb a conversion
  always_comb begin
    run = (wr_csr ? wr_on : ctrl_on) & ~I_HALT;
  end

  // halt leaves a settling debt that must be paid before sampling
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      need_settle <= 1'b0;
    end else if (I_HALT) begin
      need_settle <= 1'b1;
    end else if (state == ACC_SETTLE && settle_cnt == ACC_STAB_LAST) begin
      need_settle <= 1'b0;
    end
  end

  // settling cycle counter, cleared outside the settling state
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      settle_cnt <= '0;
    end else if (state != ACC_SETTLE || next_state != ACC_SETTLE) begin
      settle_cnt <= '0;
    end else begin
      settle_cnt <= settle_cnt + 12'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // next state: off, settle, sample, approximate, and round again
  always_comb begin
    next_state = state;
    if (!run) begin
      next_state = ACC_OFF;
    end else if (restart) begin
      // abort whatever is running and start afresh
      next_state = need_settle ? ACC_SETTLE : ACC_SAMPLE;
    end else begin
      case (state)
        ACC_OFF: begin
          // power up and begin the first conversion
          next_state = need_settle ? ACC_SETTLE : ACC_SAMPLE;
        end
        ACC_SETTLE: begin
          if (settle_cnt == ACC_STAB_LAST) begin
            next_state = ACC_SAMPLE;
          end
        end
        ACC_SAMPLE: begin
          if (tick && period_cnt == ACC_SAMPLE_LAST) begin
            next_state = ACC_APPROX;
          end
        end
        ACC_APPROX: begin
          if (tick && period_cnt == ACC_STEP_LAST) begin
            next_state = ACC_SAMPLE;
          end
        end
        default: begin
          next_state = ACC_OFF;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state <= ACC_OFF;
    end else begin
      state <= next_state;
    end
  end

  // converter clock enable: every second system cycle, realigned on
  // each phase change so a conversion always spans the same cycles
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      adc_phase <= 1'b0;
    end else if (restart || next_state != state) begin
      adc_phase <= 1'b0;
    end else begin
      adc_phase <= ~adc_phase;
    end
  end

  // a converter period closes on the second cycle of the pair
  always_comb begin
    tick = adc_phase;
  end

  // periods inside the sampling and approximation phases
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      period_cnt <= '0;
    end else if (restart || next_state != state) begin
      period_cnt <= '0;
    end else if (tick) begin
      period_cnt <= period_cnt + 4'd1;
    end
  end

  // engine strobes; sampling holds the trial, steps run on ticks
  always_comb begin
    sar_clear = (state == ACC_SAMPLE) | restart;
    sar_step = (state == ACC_APPROX) & tick & run & ~restart;
  end

  ////////////////////////////////////////////////////////////////////////////
  // approximation engine

  acc_sar_engine #(
    .RES_W(RES_W)
  ) u_sar (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_clear(sar_clear),
    .i_step(sar_step),
    .i_cmp(I_COMPARATOR),
    .o_trial(sar_trial),
    .o_result(sar_result),
    .o_done(sar_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // analog front end outputs

  // power, channel and sampling switch; the sample switch opens for
  // the approximation steps so the capacitor is isolated
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_CONVERTER_POWER <= 1'b0;
      O_CHANNEL_SELECT <= ACC_CH_RESET;
      O_SAMPLE <= 1'b0;
    end else begin
      O_CONVERTER_POWER <= (next_state != ACC_OFF);
      O_CHANNEL_SELECT <= wr_csr ?
        I_WB_DAT[ACC_CH_LSB +: ACC_CH_W] : ctrl_ch;
      O_SAMPLE <= (next_state == ACC_SAMPLE);
    end
  end

  // trial code to the dac, one register behind the engine
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_DAC_CODE <= '0;
    end else begin
      O_DAC_CODE <= sar_trial;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital view of the pins

  // the analog mux never blocks the logic path of a pin
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_PIN_LEVEL <= '0;
    end else begin
      O_PIN_LEVEL <= I_PIN_LEVEL;
    end
  end

endmodule : acc_conv_ctrl

//--- verilog/acc_pkg.sv
// shared constants for the converter control block
package acc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are indices, byte address is four times
  localparam logic [9:0] ACC_IDX_RESULT = 10'h070; // result register index
  localparam logic [9:0] ACC_IDX_CSR = 10'h071; // control/status index
  localparam logic [11:0] ACC_ADR_RESULT = {ACC_IDX_RESULT, 2'b00};
  localparam logic [11:0] ACC_ADR_CSR = {ACC_IDX_CSR, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // control/status field layout
  localparam int ACC_BIT_DONE = 7; // conversion_done_flag
  localparam int ACC_BIT_ON = 5; // converter_on
  localparam int ACC_CH_LSB = 0; // channel_select low bit
  localparam int ACC_CH_W = 4; // channel_select width

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] ACC_RESULT_RESET = 8'h00;
  localparam logic [ACC_CH_W-1:0] ACC_CH_RESET = 4'h0;
  localparam logic [31:0] ACC_BUS_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing, counted in converter clock periods
  localparam int ACC_CONV_PERIODS = 12; // whole conversion
  localparam int ACC_SAR_STEPS = 8; // approximation steps
  localparam int ACC_SAMPLE_PERIODS = ACC_CONV_PERIODS - ACC_SAR_STEPS;
  localparam logic [3:0] ACC_SAMPLE_LAST = 4'(ACC_SAMPLE_PERIODS - 1);
  localparam logic [3:0] ACC_STEP_LAST = 4'(ACC_SAR_STEPS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // settling time after leaving halt, as a least time
  localparam int ACC_CLK_PERIOD_PS = 8000; // 125 MHz system clock
  localparam int ACC_STAB_TIME_NS = 1000; // settling time after halt
  localparam int ACC_STAB_CYCLES =
    (ACC_STAB_TIME_NS * 1000 + ACC_CLK_PERIOD_PS - 1) / ACC_CLK_PERIOD_PS;
  localparam logic [11:0] ACC_STAB_LAST = 12'(ACC_STAB_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [1:0] {
    ACC_OFF,
    ACC_SETTLE,
    ACC_SAMPLE,
    ACC_APPROX
  } acc_state_type;

endpackage : acc_pkg

//--- verilog/acc_sar_engine.sv
// successive-approximation register: trial code, result and done pulse
`timescale 1ns/1ps
module acc_sar_engine
  import acc_pkg::*;
#(
  parameter int RES_W = 8 // resolution in bits
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear, // hold trial at mid scale (sampling)
  input wire logic i_step, // one approximation step this cycle
  input wire logic i_cmp, // comparator: input at or above trial
  output logic [RES_W-1:0] o_trial, // code presented to the dac
  output logic [RES_W-1:0] o_result, // last finished result
  output logic o_done // one-cycle pulse after the last step
);

  ////////////////////////////////////////////////////////////////////////////
  // internal state
  logic [RES_W-1:0] mask; // bit under trial
  logic [RES_W-1:0] kept; // trial with the tested bit decided

  // decide the tested bit from the comparator
  always_comb begin
    kept = i_cmp ? o_trial : (o_trial & ~mask);
  end

  // walk the trial bit from msb to lsb, one bit per step
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask <= '0;
      o_trial <= '0;
    end else if (i_clear) begin
      mask <= RES_W'(1) << (RES_W - 1); // start at mid scale
      o_trial <= RES_W'(1) << (RES_W - 1);
    end else if (i_step) begin
      mask <= mask >> 1;
      o_trial <= kept | (mask >> 1); // next bit tried high
    end
  end

  // capture the result at the last step and hold it until the next
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_result <= ACC_RESULT_RESET;
      o_done <= 1'b0;
    end else begin
      o_done <= i_step & mask[0];
      if (i_step && mask[0]) begin
        o_result <= kept;
      end
    end
  end

endmodule : acc_sar_engine

//--- dv/acc_conv_ctrl_props.sv
// assertions on the converter control ports
`timescale 1ns/1ps
module acc_conv_ctrl_props
  import acc_pkg::*;
#(
  parameter int RES_W = 8, // converter resolution
  parameter int PINS = 16 // port pins
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [11:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic [31:0] O_WB_DAT,
  input wire logic I_HALT,
  input wire logic O_CONVERTER_POWER,
  input wire logic [ACC_CH_W-1:0] O_CHANNEL_SELECT,
  input wire logic O_SAMPLE,
  input wire logic [RES_W-1:0] O_DAC_CODE,
  input wire logic [PINS-1:0] I_PIN_LEVEL,
  input wire logic [PINS-1:0] O_PIN_LEVEL
);
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  logic csr_wr; // control write answered this cycle
  logic wr_busy; // any write on the bus, may restart the sequence
  assign csr_wr = O_WB_ACK && I_WB_WE && I_WB_SEL[0] &&
    (I_WB_ADR[11:2] == ACC_IDX_CSR);
  assign wr_busy = I_WB_CYC && I_WB_WE;
  // mid-scale trial code shown while the input is sampled
  localparam logic [RES_W-1:0] DAC_MID = {1'b1, {(RES_W-1){1'b0}}};
  // sampling then approximation phases
  sequence s_sampling;
    O_SAMPLE [*8];
  endsequence
  sequence s_approx;
    (!O_SAMPLE) [*8] ##1 (!O_SAMPLE) [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // properties
  property p_ack_next;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK;
  endproperty
  property p_ack_once;
    @(posedge I_SYS_CLK) disable iff (I_RST) O_WB_ACK |=> !O_WB_ACK;
  endproperty
  property p_phases;
    @(posedge I_SYS_CLK) disable iff (I_RST || I_HALT || wr_busy)
    $rose(O_SAMPLE) |-> s_sampling ##1 s_approx ##1 O_SAMPLE;
  endproperty
  property p_off;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    csr_wr && !I_WB_DAT[ACC_BIT_ON] |-> ##2 !O_CONVERTER_POWER && !O_SAMPLE;
  endproperty
  property p_restart;
    @(posedge I_SYS_CLK) disable iff (I_RST || I_HALT)
    csr_wr && I_WB_DAT[ACC_BIT_ON] |-> ##[1:3] O_SAMPLE;
  endproperty
  property p_halt;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    I_HALT [*3] |-> !O_CONVERTER_POWER && !O_SAMPLE;
  endproperty
  property p_channel;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    csr_wr |-> ##2 O_CHANNEL_SELECT == $past(I_WB_DAT[3:0], 2);
  endproperty
  property p_reserved;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    O_WB_ACK && !I_WB_WE && (I_WB_ADR[11:2] == ACC_IDX_CSR) |->
      !O_WB_DAT[6] && !O_WB_DAT[4] && (O_WB_DAT[31:8] == 24'h00_0000);
  endproperty
  property p_pins;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !$past(I_RST) |-> O_PIN_LEVEL == $past(I_PIN_LEVEL);
  endproperty
  // the dac shows mid scale from the third sampling cycle to the end of the phase
  property p_dac_mid;
    @(posedge I_SYS_CLK) disable iff (I_RST)
    $rose(O_SAMPLE) |-> ##2 (O_DAC_CODE == DAC_MID) [*6];
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_phases: assert property (p_phases)
    else $error("conversion phase length wrong");
  a_off: assert property (p_off)
    else $error("converter still on");
  a_restart: assert property (p_restart)
    else $error("no restart after control write");
  a_halt: assert property (p_halt)
    else $error("converter on during halt");
  a_channel: assert property (p_channel)
    else $error("channel select wrong");
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");
  a_pins: assert property (p_pins)
    else $error("pin level not passed");
  a_dac_mid: assert property (p_dac_mid)
    else $error("trial code not mid scale while sampling");
endmodule : acc_conv_ctrl_props

bind acc_conv_ctrl acc_conv_ctrl_props #(.RES_W(RES_W), .PINS(PINS))
  acc_conv_ctrl_props_i (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT), .I_HALT(I_HALT),
  .O_CONVERTER_POWER(O_CONVERTER_POWER),
  .O_CHANNEL_SELECT(O_CHANNEL_SELECT), .O_SAMPLE(O_SAMPLE),
  .O_DAC_CODE(O_DAC_CODE),
  .I_PIN_LEVEL(I_PIN_LEVEL), .O_PIN_LEVEL(O_PIN_LEVEL));

//--- dv/acc_front_end_model.sv
// analog front end model: comparator against a level per input
`timescale 1ns/1ps
module acc_front_end_model
  import acc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_power, // analog power
  input wire logic [ACC_CH_W-1:0] i_channel, // mux select
  input wire logic [7:0] i_dac_code, // trial code
  output logic o_comparator // input at or above trial
);
  logic [7:0] level; // level of the selected input
  logic junk = 1'b0; // meaningless answer while powered down
  // input n sits at {n, not n}; plain input, no pull-up, no interrupt
  assign level = {i_channel, ~i_channel};
  // toggles so an unpowered comparator never looks valid
  always_ff @(posedge i_clk) begin
    junk <= ~junk;
  end
  // comparator answers only while powered
  assign o_comparator = i_power ? (level >= i_dac_code) : junk;
endmodule : acc_front_end_model

//--- dv/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); \
  end \
end
module tb
  import acc_pkg::*;
;
  typedef struct {logic [7:0] wdat, control_status_reg, res;} acc_row_type;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic ack, halt = 1'b0, cmp, power, sample;
  logic [3:0] chan;
  logic [7:0] dac, q;
  logic [15:0] pin_in = 16'h0000, pin_out;
  int err_count = 0, check_count = 0, n;
  // control write, readback with done set, result, per row
  acc_row_type rows [4] = '{'{8'h20, 8'hA0, 8'h0F},
    '{8'h75, 8'hA5, 8'h5A}, '{8'h2A, 8'hAA, 8'hA5}, '{8'h7F, 8'hAF, 8'hF0}};
  acc_conv_ctrl acc_conv_ctrl_i (.I_SYS_CLK(clk), .I_RST(rst),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
    .I_HALT(halt), .I_COMPARATOR(cmp), .O_CONVERTER_POWER(power),
    .O_CHANNEL_SELECT(chan), .O_SAMPLE(sample), .O_DAC_CODE(dac),
    .I_PIN_LEVEL(pin_in), .O_PIN_LEVEL(pin_out));
  acc_front_end_model acc_front_end_model_i (.i_clk(clk), .i_power(power),
    .i_channel(chan), .i_dac_code(dac), .o_comparator(cmp));
  ////////////////////////////////////////////////////////////////////////////
  // clock and tasks
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // a wait that ran out ends the run
  task automatic fail(input string nm);
    err_count++;
    $display("ERROR %s expected answer seen none", nm);
    finish_test();
  endtask : fail
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [7:0] d, input logic [3:0] s, output logic [7:0] r);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (k == 50) fail("bus ack");
  endtask : wb
  // poll control/status until the done flag shows
  task automatic wait_done(output logic [7:0] r);
    int k;
    k = 0;
    r = 8'h00;
    while (r[ACC_BIT_DONE] !== 1'b1 && k < 300) begin
      wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, r);
      k++;
    end
    if (k == 300) fail("done flag");
  endtask : wait_done
  // count edges until the sample switch shows v
  task automatic wait_s(input logic v, inout int c);
    int k;
    k = 0;
    while (sample !== v && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k == 200) fail("sample switch");
    c += k;
  endtask : wait_s
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    fail("watchdog");
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, q);
    `CHK("csr reset", 8'h00, q)
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    `CHK("result reset", 8'h00, q)
    // ordinary conversions, one row each
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ACC_ADR_CSR, rows[i].wdat, 4'h1, q);
      wait_done(q);
      `CHK("csr done", rows[i].control_status_reg, q)
      wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
      `CHK("result", rows[i].res, q)
      wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, q);
      `CHK("csr cleared", rows[i].control_status_reg & 8'h7F, q)
    end
    // continuous conversions with no further writes
    wait_done(q);
    `CHK("next done", 8'hAF, q)
    n = 0;
    wait_s(1'b0, n);
    wait_s(1'b1, n);
    n = 0;
    wait_s(1'b0, n);
    wait_s(1'b1, n);
    `CHK("period", 24, n)
    // control write while done aborts and clears
    wb(1'b1, ACC_ADR_CSR, 8'h25, 4'h1, q);
    wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, q);
    `CHK("abort", 8'h25, q)
    // refused writes: no byte lane, then a result write after completion
    // that must leave the held result alone
    wb(1'b1, ACC_ADR_CSR, 8'h00, 4'h0, q);
    wait_done(q);
    wb(1'b1, ACC_ADR_RESULT, 8'hC3, 4'h1, q);
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    `CHK("read only", 8'h5A, q)
    wb(1'b0, 12'h000, 8'h00, 4'h1, q);
    `CHK("unmapped", 8'h00, q)
    // switched off: no conversions, result kept
    wb(1'b1, ACC_ADR_CSR, 8'h03, 4'h1, q);
    repeat (60) @(posedge clk);
    `CHK("power off", 1'b0, power)
    wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, q);
    `CHK("off csr", 8'h03, q)
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    `CHK("off result", 8'h5A, q)
    // halt stops the converter; sampling waits out the settling time
    wb(1'b1, ACC_ADR_CSR, 8'h2A, 4'h1, q);
    repeat (10) @(posedge clk);
    halt <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("halt power", 1'b0, power)
    halt <= 1'b0;
    n = 0;
    wait_s(1'b1, n);
    `CHK("settle", 1'b1, n >= ACC_STAB_CYCLES)
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    wait_done(q);
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    `CHK("after halt", 8'hA5, q)
    // pins still read as logic levels
    pin_in <= 16'hA55A;
    repeat (2) @(posedge clk);
    `CHK("pins", 16'hA55A, pin_out)
    // reset in mid-run while converting: both registers back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset power", 1'b0, power)
    wb(1'b0, ACC_ADR_CSR, 8'h00, 4'h1, q);
    `CHK("csr mid reset", 8'h00, q)
    wb(1'b0, ACC_ADR_RESULT, 8'h00, 4'h1, q);
    `CHK("result mid reset", 8'h00, q)
    finish_test();
  end
endmodule : tb
